// ---- common/dtc_regs.vh ----
`ifndef DTC_REGS_VH
`define DTC_REGS_VH

// Register byte offsets on the AXI4-Lite bus.
`define DTC_OFF_CTRL   8'h00
`define DTC_OFF_MODE   8'h04
`define DTC_OFF_BITOP  8'h08
`define DTC_OFF_CNT0   8'h0C
`define DTC_OFF_CNT1   8'h10
`define DTC_OFF_STAT   8'h14
`define DTC_OFF_MASK   8'h18

// Reset values.
`define DTC_RST_CTRL   8'h00
`define DTC_RST_MODE   8'h00
`define DTC_RST_CNT    16'h0000
`define DTC_RST_IRQ    4'h0

// Control register bit positions.
`define DTC_CTL_OVF1   7
`define DTC_CTL_RUN1   6
`define DTC_CTL_OVF0   5
`define DTC_CTL_RUN0   4
`define DTC_CTL_EXF1   3
`define DTC_CTL_EXT1   2
`define DTC_CTL_EXF0   1
`define DTC_CTL_EXT0   0

// Mode nibble field positions, counter n uses nibble n.
`define DTC_MD_GATE    3
`define DTC_MD_CT      2
`define DTC_MD_M1      1
`define DTC_MD_M0      0

// Operating modes.
`define DTC_MODE_13    2'b00
`define DTC_MODE_16    2'b01
`define DTC_MODE_AR8   2'b10
`define DTC_MODE_SPLIT 2'b11

// Interrupt status and mask bit positions.
`define DTC_IRQ_OVF0   0
`define DTC_IRQ_OVF1   1
`define DTC_IRQ_EXT0   2
`define DTC_IRQ_EXT1   3

// AXI responses.
`define DTC_RESP_OKAY  2'b00
`define DTC_RESP_SLV   2'b10

`endif

// ---- testbench/dtc_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dtc_core_model (
  input  wire logic       aclk,    // Clock.
  input  wire logic       aresetn, // Reset, low.
  input  wire logic       en,      // Servicing allowed.
  input  wire logic [3:0] dly,     // Wait before vectoring.
  input  wire logic [3:0] irq_req, // Pending flags.
  output var  logic [3:0] vec_ack  // One-cycle vector pulses.
);
  logic [3:0] cnt_r;
  logic       hold_r;

  // Vector to the lowest pending index after dly cycles. The pause after
  // each pulse lets the cleared flag land, or a flag would be served twice.
  always @(posedge aclk) begin
    vec_ack <= 4'h0;
    hold_r <= |vec_ack;
    if (!aresetn || !en || hold_r || (|vec_ack) || irq_req == 4'h0) begin
      cnt_r <= 4'h0;
    end else if (cnt_r < dly) begin
      cnt_r <= cnt_r + 4'h1;
    end else begin
      cnt_r <= 4'h0;
      vec_ack <= irq_req & (~irq_req + 4'h1);
    end
  end
endmodule
`default_nettype wire

// ---- testbench/dtc_timer_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_checker (
  input wire logic        aclk,            // Clock.
  input wire logic        aresetn,         // Reset, low.
  input wire logic        ce,              // Clock enable.
  input wire logic        s_axi_awvalid,   // Write address valid.
  input wire logic        s_axi_awready,   // Write address ready.
  input wire logic        s_axi_wvalid,    // Write data valid.
  input wire logic        s_axi_wready,    // Write data ready.
  input wire logic        s_axi_bvalid,    // Write response valid.
  input wire logic        s_axi_bready,    // Write response ready.
  input wire logic        s_axi_arvalid,   // Read address valid.
  input wire logic        s_axi_arready,   // Read address ready.
  input wire logic [31:0] s_axi_rdata,     // Read data.
  input wire logic        s_axi_rvalid,    // Read data valid.
  input wire logic        s_axi_rready,    // Read data ready.
  input wire logic        ext_irq_pin_0_n, // Interrupt pin 0.
  input wire logic        ext_irq_pin_1_n, // Interrupt pin 1.
  input wire logic        vec_ack_ext0,    // Vector to handler 0.
  input wire logic [3:0]  irq_req,         // Pending flags.
  input wire logic        irq              // Interrupt line.
);
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Bus answers come one cycle after the request is taken.
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_wr_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write not answered");

  // Answers stand until taken, and no new read is accepted meanwhile.
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_ar_refuse;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_refuse: assert property (p_ar_refuse) else $error("read taken while busy");

  // A low enable freezes the flags and the interrupt line.
  property p_ce_freeze;
    !ce |=> $stable(irq_req) && $stable(irq);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("flags moved while frozen");

  // A falling pin sets its flag in either trigger type; a pin that is high
  // cannot re-set it, so a vector pulse to handler 0 then must clear flag 0.
  property p_ext0_set;
    ce && $past(ce) && $fell(ext_irq_pin_0_n) |=> irq_req[0];
  endproperty
  a_ext0_set: assert property (p_ext0_set) else $error("pin 0 flag missed");
  property p_ext1_set;
    ce && $past(ce) && $fell(ext_irq_pin_1_n) |=> irq_req[2];
  endproperty
  a_ext1_set: assert property (p_ext1_set) else $error("pin 1 flag missed");
  property p_ext0_clr;
    ce && vec_ack_ext0 && ext_irq_pin_0_n |=> !irq_req[0];
  endproperty
  a_ext0_clr: assert property (p_ext0_clr) else $error("pin 0 flag kept");
endmodule
bind dtc_timer dtc_timer_checker u_chk (.*);
`default_nettype wire

// ---- testbench/dtc_timer_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dtc_regs.vh"
module dtc_timer_test;
  typedef struct {
    logic [7:0]  a;
    logic [31:0] d;
    logic [7:0]  ra;
    logic [31:0] e;
    logic [1:0]  r;
  } dtc_row_t;
  localparam logic [1:0] okr = `DTC_RESP_OKAY;
  logic        aclk, aresetn, ce, srv_en, count_pin_0, count_pin_1, irq;
  logic        ext_irq_pin_0_n, ext_irq_pin_1_n, s_axi_rvalid, s_axi_rready;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        vec_ack_ext0, vec_ack_ovf0, vec_ack_ext1, vec_ack_ovf1;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb, irq_req, dly;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          n_errors, cmp_count, p, t;
  // Write, then read back; bit operations are seen through the control word, the mode word or the bit read-back.
  dtc_row_t rows [8] = '{
    '{`DTC_OFF_CTRL, 32'h01, `DTC_OFF_CTRL, 32'h01, okr},
    '{`DTC_OFF_BITOP, 32'h0A, `DTC_OFF_CTRL, 32'h05, okr},
    '{`DTC_OFF_BITOP, 32'h00, `DTC_OFF_CTRL, 32'h04, okr},
    '{`DTC_OFF_MODE, 32'h69, `DTC_OFF_MODE, 32'h69, okr},
    '{`DTC_OFF_BITOP, 32'h03, `DTC_OFF_MODE, 32'h69, okr},
    '{`DTC_OFF_MASK, 32'h0F, `DTC_OFF_MASK, 32'h0F, okr},
    '{`DTC_OFF_BITOP, 32'h0A, `DTC_OFF_BITOP, 32'h01, okr},
    '{8'h1C, 32'hFF, 8'h1C, 32'h00, `DTC_RESP_SLV}
  };

  dtc_timer u_dut (.*);
  dtc_core_model u_core (
    .aclk    (aclk),
    .aresetn (aresetn),
    .en      (ce && srv_en),
    .dly     (dly),
    .irq_req (irq_req),
    .vec_ack ({vec_ack_ovf1, vec_ack_ext1, vec_ack_ovf0, vec_ack_ext0})
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t ns: saw %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic bail();
    n_errors++;
    $display("[ERR] %0t ns: wait ran out", $time);
    finish_test();
  endtask
  // Address and data go out together; each drops once taken. Ready for the
  // answer comes a cycle late so that the slave must hold it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int   i;
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b0;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_bvalid && s_axi_bready) break;
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (i == 1) s_axi_bready <= 1'b1;
    end
    if (i == 50) bail();
    chk(s_axi_bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b0;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (i == 1) s_axi_rready <= 1'b1;
    end
    if (i == 50) bail();
    rv = s_axi_rdata;
    chk(s_axi_rresp, er);
  endtask
  task automatic wt(input int b, input logic v);
    int i;
    for (i = 0; i < 300 && irq_req[b] !== v; i++) @(posedge aclk);
    if (i == 300) bail();
  endtask
  // One falling edge on both count pins, two cycles per level.
  task automatic pulse();
    {count_pin_1, count_pin_0} <= 2'b11;
    repeat (2) @(posedge aclk);
    {count_pin_1, count_pin_0} <= 2'b00;
    repeat (2) @(posedge aclk);
  endtask

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  initial begin
    {aresetn, srv_en, count_pin_0, count_pin_1, dly} = 8'h00;
    {ce, ext_irq_pin_0_n, ext_irq_pin_1_n, s_axi_wstrb} = 7'h7F;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    n_errors = 0;
    cmp_count = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[k]) begin
      wr(rows[k].a, rows[k].d, rows[k].r);
      rd(rows[k].ra, rows[k].r);
      chk(rv, rows[k].e);
      $display("row %0d done", k);
    end
    // Auto-reload overflow with its interrupt first masked, then unmasked.
    wr(`DTC_OFF_MASK, 32'h0E, okr);
    wr(`DTC_OFF_MODE, 32'h02, okr);
    wr(`DTC_OFF_CNT0, 32'hFEFD, okr);
    wr(`DTC_OFF_BITOP, 32'h0C, okr);
    wt(1, 1'b1);
    chk(irq, 1'b0);
    wr(`DTC_OFF_BITOP, 32'h04, okr);
    wr(`DTC_OFF_MASK, 32'h0F, okr);
    chk(irq, 1'b1);
    rd(`DTC_OFF_CNT0, okr);
    chk(rv[15:1], 15'h7F7F);
    rd(`DTC_OFF_STAT, okr);
    chk(rv, 32'h01);
    chk(irq, 1'b0);
    srv_en <= 1'b1;
    wt(1, 1'b0);
    chk(irq_req[1], 1'b0);
    srv_en <= 1'b0;
    $display("auto-reload test done");
    // Split mode: the high byte runs on the second run bit, counter 1 holds.
    wr(`DTC_OFF_MODE, 32'h33, okr);
    wr(`DTC_OFF_CNT1, 32'h1234, okr);
    wr(`DTC_OFF_CNT0, 32'hFD00, okr);
    wr(`DTC_OFF_BITOP, 32'h0E, okr);
    ce <= 1'b0;
    repeat (4) @(posedge aclk);
    ce <= 1'b1;
    wt(3, 1'b1);
    wr(`DTC_OFF_BITOP, 32'h06, okr);
    rd(`DTC_OFF_CNT1, okr);
    chk(rv, 32'h1234);
    rd(`DTC_OFF_CNT0, okr);
    chk(rv[7:0], 8'h00);
    $display("split test done");
    // Both counters on their pins, gated; edges while the gate is low are lost.
    wr(`DTC_OFF_MODE, 32'hDD, okr);
    wr(`DTC_OFF_CNT0, 32'h0, okr);
    wr(`DTC_OFF_CNT1, 32'h0, okr);
    wr(`DTC_OFF_BITOP, 32'h0C, okr);
    wr(`DTC_OFF_BITOP, 32'h0E, okr);
    repeat (3) pulse();
    {ext_irq_pin_1_n, ext_irq_pin_0_n} <= 2'b00;
    repeat (2) pulse();
    {ext_irq_pin_1_n, ext_irq_pin_0_n} <= 2'b11;
    wr(`DTC_OFF_CTRL, 32'h00, okr);
    rd(`DTC_OFF_CNT0, okr);
    chk(rv, 32'h3);
    rd(`DTC_OFF_CNT1, okr);
    chk(rv, 32'h3);
    $display("gated count test done");
    // Thirteen-bit mode on both pins: the fifth low bit carries into the high byte.
    wr(`DTC_OFF_MODE, 32'h44, okr);
    wr(`DTC_OFF_CNT0, 32'hFF1E, okr);
    wr(`DTC_OFF_CNT1, 32'hFF1E, okr);
    wr(`DTC_OFF_BITOP, 32'h0C, okr);
    wr(`DTC_OFF_BITOP, 32'h0E, okr);
    repeat (2) pulse();
    chk(irq_req, 4'hA);
    rd(`DTC_OFF_CNT0, okr);
    chk(rv, 32'h0);
    rd(`DTC_OFF_CNT1, okr);
    chk(rv, 32'h0);
    $display("thirteen-bit test done");
    // Each pin in each trigger type, served by a slow core: a held low level
    // sets the flag again after service, an edge does not.
    dly <= 4'h5;
    for (p = 0; p < 2; p++) begin
      for (t = 0; t < 2; t++) begin
        wr(`DTC_OFF_CTRL, t << (2 * p), okr);
        rd(`DTC_OFF_STAT, okr);
        srv_en <= 1'b1;
        {ext_irq_pin_1_n, ext_irq_pin_0_n} <= (p == 0) ? 2'b10 : 2'b01;
        repeat (2) @(posedge aclk);
        // A released pin lets the vector clear an edge flag for good.
        if (t == 1) {ext_irq_pin_1_n, ext_irq_pin_0_n} <= 2'b11;
        repeat (14) @(posedge aclk);
        srv_en <= 1'b0;
        repeat (3) @(posedge aclk);
        chk(irq_req[2 * p], t == 0);
        rd(`DTC_OFF_STAT, okr);
        chk(rv[2 + p], 1'b1);
        {ext_irq_pin_1_n, ext_irq_pin_0_n} <= 2'b11;
        repeat (2) @(posedge aclk);
      end
    end
    $display("pin trigger test done");
    // A second reset while a counter runs returns control, mode and counter 0 to their reset values.
    wr(`DTC_OFF_BITOP, 32'h0C, okr);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`DTC_OFF_CTRL, okr);
    chk(rv, {24'h0, `DTC_RST_CTRL});
    rd(`DTC_OFF_MODE, okr);
    chk(rv, {24'h0, `DTC_RST_MODE});
    rd(`DTC_OFF_CNT0, okr);
    chk(rv, {16'h0, `DTC_RST_CNT});
    $display("reset test done");
    finish_test();
  end
endmodule
`default_nettype wire

// ---- verilog/dtc_timer.v ----
`timescale 1ns/1ps
`default_nettype none
`include "dtc_regs.vh"

module dtc_timer (
  input  wire        aclk,            // System clock, 25 MHz.
  input  wire        aresetn,         // Synchronous reset, active low.
  input  wire        ce,              // Clock enable; all state frozen while low.
  input  wire [7:0]  s_axi_awaddr,    // Write address.
  input  wire        s_axi_awvalid,   // Write address valid.
  output wire        s_axi_awready,   // Write address ready.
  input  wire [31:0] s_axi_wdata,     // Write data.
  input  wire [3:0]  s_axi_wstrb,     // Write byte strobes.
  input  wire        s_axi_wvalid,    // Write data valid.
  output wire        s_axi_wready,    // Write data ready.
  output reg  [1:0]  s_axi_bresp,     // Write response.
  output reg         s_axi_bvalid,    // Write response valid.
  input  wire        s_axi_bready,    // Write response ready.
  input  wire [7:0]  s_axi_araddr,    // Read address.
  input  wire        s_axi_arvalid,   // Read address valid.
  output wire        s_axi_arready,   // Read address ready.
  output reg  [31:0] s_axi_rdata,     // Read data.
  output reg  [1:0]  s_axi_rresp,     // Read response.
  output reg         s_axi_rvalid,    // Read data valid.
  input  wire        s_axi_rready,    // Read data ready.
  input  wire        ext_irq_pin_0_n, // External interrupt pin 0, active low.
  input  wire        ext_irq_pin_1_n, // External interrupt pin 1, active low.
  input  wire        count_pin_0,     // Count input pin of counter 0.
  input  wire        count_pin_1,     // Count input pin of counter 1.
  input  wire        vec_ack_ext0,    // Core vectors to external handler 0.
  input  wire        vec_ack_ovf0,    // Core vectors to overflow handler 0.
  input  wire        vec_ack_ext1,    // Core vectors to external handler 1.
  input  wire        vec_ack_ovf1,    // Core vectors to overflow handler 1.
  output wire [3:0]  irq_req,         // Requests {ovf1, ext1, ovf0, ext0}.
  output wire        irq              // Level interrupt, unmasked status set.
);

  // Register address decode, shared by the write and read paths.
  localparam SEL_CTRL  = 3'd0;
  localparam SEL_MODE  = 3'd1;
  localparam SEL_BITOP = 3'd2;
  localparam SEL_CNT0  = 3'd3;
  localparam SEL_CNT1  = 3'd4;
  localparam SEL_STAT  = 3'd5;
  localparam SEL_MASK  = 3'd6;
  localparam SEL_NONE  = 3'd7;

  function [2:0] dtc_decode;
    input [7:0] addr;
    begin
      case (addr)
        `DTC_OFF_CTRL:  dtc_decode = SEL_CTRL;
        `DTC_OFF_MODE:  dtc_decode = SEL_MODE;
        `DTC_OFF_BITOP: dtc_decode = SEL_BITOP;
        `DTC_OFF_CNT0:  dtc_decode = SEL_CNT0;
        `DTC_OFF_CNT1:  dtc_decode = SEL_CNT1;
        `DTC_OFF_STAT:  dtc_decode = SEL_STAT;
        `DTC_OFF_MASK:  dtc_decode = SEL_MASK;
        default:        dtc_decode = SEL_NONE;
      endcase
    end
  endfunction

  // One counting step for a byte pair; returns {overflow, high, low}.
  function [16:0] dtc_step;
    input [1:0] mode;
    input [7:0] lo;
    input [7:0] hi;
    begin
      case (mode)
        `DTC_MODE_13: begin
          // Low five bits prescale the high byte.
          if (lo[4:0] == 5'h1F) begin
            dtc_step = {(hi == 8'hFF), hi + 8'h01, lo[7:5], 5'h00};
          end else begin
            dtc_step = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};
          end
        end
        `DTC_MODE_16: begin
          dtc_step = {({hi, lo} == 16'hFFFF), {hi, lo} + 16'h0001};
        end
        `DTC_MODE_AR8: begin
          // Reload from the high byte so the period needs no software.
          if (lo == 8'hFF) begin
            dtc_step = {1'b1, hi, hi};
          end else begin
            dtc_step = {1'b0, hi, lo + 8'h01};
          end
        end
        default: begin
          dtc_step = {(lo == 8'hFF), hi, lo + 8'h01};
        end
      endcase
    end
  endfunction

  reg  [7:0]  ctrl_r;
  reg  [7:0]  mode_r;
  reg  [2:0]  bit_idx_r;
  reg  [7:0]  lo0_r;
  reg  [7:0]  hi0_r;
  reg  [7:0]  lo1_r;
  reg  [7:0]  hi1_r;
  reg  [3:0]  stat_r;
  reg  [3:0]  mask_r;
  reg  [1:0]  irq_pin_q_r;
  reg  [1:0]  cnt_pin_q_r;
  reg         aw_have_r;
  reg  [7:0]  awaddr_r;
  reg         w_have_r;
  reg  [31:0] wdata_r;
  reg  [3:0]  wstrb_r;

  // Bus handshakes; ready drops while frozen so no beat is lost.
  assign s_axi_awready = ce & ~aw_have_r & ~s_axi_bvalid;
  assign s_axi_wready  = ce & ~w_have_r & ~s_axi_bvalid;
  assign s_axi_arready = ce & ~s_axi_rvalid;

  wire        aw_hs  = s_axi_awvalid & s_axi_awready;
  wire        w_hs   = s_axi_wvalid & s_axi_wready;
  wire        ar_hs  = s_axi_arvalid & s_axi_arready;
  wire        do_wr  = (aw_have_r | aw_hs) & (w_have_r | w_hs) & ~s_axi_bvalid & ce;
  wire [7:0]  wr_adr = aw_have_r ? awaddr_r : s_axi_awaddr;
  wire [31:0] wr_dat = w_have_r ? wdata_r : s_axi_wdata;
  wire [3:0]  wr_stb = w_have_r ? wstrb_r : s_axi_wstrb;
  wire [2:0]  wr_sel = dtc_decode(wr_adr);
  wire [2:0]  rd_sel = dtc_decode(s_axi_araddr);
  wire        wr_b0  = do_wr & wr_stb[0];
  wire        wr_b1  = do_wr & wr_stb[1];

  // Pin qualification and count sources.
  wire [1:0] irq_pin_n = {ext_irq_pin_1_n, ext_irq_pin_0_n};
  wire [1:0] cnt_pin   = {count_pin_1, count_pin_0};
  wire [1:0] run_bit   = {ctrl_r[`DTC_CTL_RUN1], ctrl_r[`DTC_CTL_RUN0]};
  wire [1:0] irq_edge;
  wire [1:0] cnt_tick;
  wire [1:0] irq_lvl;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_src
      // Inputs are synchronous, so one stored sample finds the falling edge.
      assign irq_edge[g] = irq_pin_q_r[g] & ~irq_pin_n[g];
      assign irq_lvl[g]  = ~irq_pin_n[g];
      // Gated run waits for the pin high; counting source per select bit.
      assign cnt_tick[g] = run_bit[g] &
                           (~mode_r[4*g+`DTC_MD_GATE] | irq_pin_n[g]) &
                           (mode_r[4*g+`DTC_MD_CT] ?
                            (cnt_pin_q_r[g] & ~cnt_pin[g]) : 1'b1);
    end
  endgenerate

  wire [1:0]  mode0  = {mode_r[`DTC_MD_M1], mode_r[`DTC_MD_M0]};
  wire [1:0]  mode1  = {mode_r[4+`DTC_MD_M1], mode_r[4+`DTC_MD_M0]};
  wire        split0 = (mode0 == `DTC_MODE_SPLIT);
  wire [16:0] step0  = dtc_step(mode0, lo0_r, hi0_r);
  wire [16:0] step1  = dtc_step(mode1, lo1_r, hi1_r);

  // In split mode the high byte of counter 0 is a plain timer on run bit 1.
  wire        hi0_tick = split0 & ctrl_r[`DTC_CTL_RUN1];
  wire        run1     = cnt_tick[1] & (mode1 != `DTC_MODE_SPLIT);
  wire        ovf0_ev  = cnt_tick[0] & step0[16];
  wire        ovf1_ev  = split0 ? (hi0_tick & (hi0_r == 8'hFF))
                                : (run1 & step1[16]);

  // Edge events honour the type bit; level mode follows the pin.
  wire        ext0_ev = ctrl_r[`DTC_CTL_EXT0] ? irq_edge[0] : irq_lvl[0];
  wire        ext1_ev = ctrl_r[`DTC_CTL_EXT1] ? irq_edge[1] : irq_lvl[1];

  // Control register next value: software write, then vector clears,
  // then hardware sets, so an event in the clearing cycle survives.
  reg [7:0] ctrl_nxt;
  always @* begin
    ctrl_nxt = ctrl_r;
    if (wr_b0 && wr_sel == SEL_CTRL) begin
      ctrl_nxt = wr_dat[7:0];
    end else if (do_wr && wr_sel == SEL_BITOP) begin
      ctrl_nxt[wr_dat[2:0]] = wr_dat[3];
    end
    if (vec_ack_ovf0) begin
      ctrl_nxt[`DTC_CTL_OVF0] = 1'b0;
    end
    if (vec_ack_ovf1) begin
      ctrl_nxt[`DTC_CTL_OVF1] = 1'b0;
    end
    if (vec_ack_ext0) begin
      ctrl_nxt[`DTC_CTL_EXF0] = 1'b0;
    end
    if (vec_ack_ext1) begin
      ctrl_nxt[`DTC_CTL_EXF1] = 1'b0;
    end
    if (ovf0_ev) begin
      ctrl_nxt[`DTC_CTL_OVF0] = 1'b1;
    end
    if (ovf1_ev) begin
      ctrl_nxt[`DTC_CTL_OVF1] = 1'b1;
    end
    if (ext0_ev) begin
      ctrl_nxt[`DTC_CTL_EXF0] = 1'b1;
    end
    if (ext1_ev) begin
      ctrl_nxt[`DTC_CTL_EXF1] = 1'b1;
    end
  end

  // Status is cleared by a read of itself; a new event in that cycle wins.
  wire [3:0] stat_ev  = {ext1_ev, ext0_ev, ovf1_ev, ovf0_ev};
  wire       stat_rd  = ar_hs & (rd_sel == SEL_STAT);
  wire [3:0] stat_nxt = (stat_rd ? 4'h0 : stat_r) | stat_ev;

  // Control, mode, status and the pin samples.
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r      <= `DTC_RST_CTRL;
      mode_r      <= `DTC_RST_MODE;
      bit_idx_r   <= 3'h0;
      stat_r      <= `DTC_RST_IRQ;
      mask_r      <= `DTC_RST_IRQ;
      irq_pin_q_r <= 2'h3;
      cnt_pin_q_r <= 2'h0;
    end else if (ce) begin
      ctrl_r      <= ctrl_nxt;
      stat_r      <= stat_nxt;
      irq_pin_q_r <= irq_pin_n;
      cnt_pin_q_r <= cnt_pin;
      // The mode register takes only whole-byte writes.
      if (wr_b0 && wr_sel == SEL_MODE) begin
        mode_r <= wr_dat[7:0];
      end
      if (do_wr && wr_sel == SEL_BITOP) begin
        bit_idx_r <= wr_dat[2:0];
      end
      if (wr_b0 && wr_sel == SEL_MASK) begin
        mask_r <= wr_dat[3:0];
      end
    end
  end

  // Counter bytes; a software write beats a count in the same cycle.
  always @(posedge aclk) begin
    if (!aresetn) begin
      {hi0_r, lo0_r} <= `DTC_RST_CNT;
      {hi1_r, lo1_r} <= `DTC_RST_CNT;
    end else if (ce) begin
      if (wr_b0 && wr_sel == SEL_CNT0) begin
        lo0_r <= wr_dat[7:0];
      end else if (cnt_tick[0]) begin
        lo0_r <= step0[7:0];
      end
      if (wr_b1 && wr_sel == SEL_CNT0) begin
        hi0_r <= wr_dat[15:8];
      end else if (hi0_tick) begin
        hi0_r <= hi0_r + 8'h01;
      end else if (cnt_tick[0] && !split0) begin
        hi0_r <= step0[15:8];
      end
      if (wr_b0 && wr_sel == SEL_CNT1) begin
        lo1_r <= wr_dat[7:0];
      end else if (run1) begin
        lo1_r <= step1[7:0];
      end
      if (wr_b1 && wr_sel == SEL_CNT1) begin
        hi1_r <= wr_dat[15:8];
      end else if (run1) begin
        hi1_r <= step1[15:8];
      end
    end
  end

  // Write channel capture; address and data may come in either order.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r    <= 1'b0;
      awaddr_r     <= 8'h00;
      w_have_r     <= 1'b0;
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DTC_RESP_OKAY;
    end else if (ce) begin
      if (do_wr) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_sel == SEL_NONE) ? `DTC_RESP_SLV : `DTC_RESP_OKAY;
      end else begin
        if (aw_hs) begin
          aw_have_r <= 1'b1;
          awaddr_r  <= s_axi_awaddr;
        end
        if (w_hs) begin
          w_have_r <= 1'b1;
          wdata_r  <= s_axi_wdata;
          wstrb_r  <= s_axi_wstrb;
        end
        if (s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // Read data mux, registered one cycle after the address is taken.
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (rd_sel)
      SEL_CTRL:  rd_mux[7:0]  = ctrl_r;
      SEL_MODE:  rd_mux[7:0]  = mode_r;
      SEL_BITOP: rd_mux[0]    = ctrl_r[bit_idx_r];
      SEL_CNT0:  rd_mux[15:0] = {hi0_r, lo0_r};
      SEL_CNT1:  rd_mux[15:0] = {hi1_r, lo1_r};
      SEL_STAT:  rd_mux[3:0]  = stat_r;
      SEL_MASK:  rd_mux[3:0]  = mask_r;
      default:   rd_mux       = 32'h0000_0000;
    endcase
  end

  // Read channel.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `DTC_RESP_OKAY;
    end else if (ce) begin
      if (ar_hs) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= (rd_sel == SEL_NONE) ? `DTC_RESP_SLV : `DTC_RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Requests to the core come straight from the flag bits.
  assign irq_req = {ctrl_r[`DTC_CTL_OVF1], ctrl_r[`DTC_CTL_EXF1],
                    ctrl_r[`DTC_CTL_OVF0], ctrl_r[`DTC_CTL_EXF0]};
  assign irq     = |(stat_r & mask_r);

endmodule

`default_nettype wire
